/* dcg_clock_gen.sv */
// dcg_clock_gen: register file and clock generation for the dual codec
// assumes apb master on sys_clk; crystal and external clocks are sampled pins
// sys_clk must be much faster than crystal_clock_in, since the crystal is oversampled here
`timescale 1ns/1ps
module dcg_clock_gen (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [5:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        crystal_clock_in,
    input  wire logic        codec0_ext_oversample_clk,
    input  wire logic        codec1_ext_oversample_clk,
    input  wire logic        absolute_powerdown_in_n,
    output logic             oscillator_enable,
    output logic             oversampling_clock0,
    output logic             oversampling_clock1,
    output logic             serial_bit_clock0,
    output logic             serial_bit_clock1,
    output logic             sample_tick0,
    output logic             sample_tick1,
    output logic             soft_reset_pulse,
    output logic [6:0]       codec0_power_ctrl,
    output logic [6:0]       codec1_power_ctrl,
    output logic [6:0]       codec0_analog_ctrl,
    output logic [6:0]       codec1_analog_ctrl
);
    typedef struct packed {
        logic [6:0] pwr0;
        logic [6:0] pwr1;
        logic [6:0] ana0;
        logic [6:0] ana1;
        logic [6:0] clk0;
        logic [6:0] clk1;
        logic [6:0] ls0;
        logic [6:0] ls1;
        logic [6:0] ga;
        logic [6:0] gb;
        logic [6:0] gc;
        logic [6:0] gd;
        logic       sw_rst;
        logic       x_q;
        logic       m0_q;
        logic       m1_q;
        logic       x_t;
        logic       m0_t;
        logic       m1_t;
        logic [31:0] rdata;
        logic        err;
    } dcg_top_st_t;
    dcg_top_st_t st_q, st_d;

    logic       pd_n;
    logic       xtal_s;
    logic       m0_s;
    logic       m1_s;
    logic       run;
    logic       wr;
    logic       rd;
    logic       hit;
    logic [6:0] rd_val;
    logic       osr0;
    logic       osr1;
    logic       fs0;
    logic       fs1;

    function automatic logic [5:0] hs_clip(input logic [5:0] v);
        if (v < dcg_pkg::HS_DIV_MIN) begin
            hs_clip = dcg_pkg::HS_DIV_MIN;
        end else begin
            hs_clip = v;
        end
    endfunction

    function automatic logic [6:0] ls_clip(input logic [6:0] v);
        if (v < dcg_pkg::LS_DIV_MIN) begin
            ls_clip = dcg_pkg::LS_DIV_MIN;
        end else begin
            ls_clip = v;
        end
    endfunction

    dcg_sync3 u_pd (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .async_in  (absolute_powerdown_in_n),
        .level_out (pd_n)
    );
    dcg_sync3 u_xtal (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .async_in  (crystal_clock_in),
        .level_out (xtal_s)
    );
    dcg_sync3 u_m0 (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .async_in  (codec0_ext_oversample_clk),
        .level_out (m0_s)
    );
    dcg_sync3 u_m1 (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .async_in  (codec1_ext_oversample_clk),
        .level_out (m1_s)
    );

    // power-down blocks writes and clears the divider chains; register contents are kept
    assign run = pd_n; // R2
    assign wr  = psel && penable && pwrite;
    assign rd  = psel && !penable && !pwrite;

    always_comb begin
        hit    = 1'b1;
        rd_val = 7'h00;
        case (paddr)
            dcg_pkg::OFF_CNTL0_0:  rd_val = st_q.pwr0; // R19
            dcg_pkg::OFF_CNTL0_1:  rd_val = st_q.pwr1;
            dcg_pkg::OFF_CNTL1_0:  rd_val = st_q.ana0;
            dcg_pkg::OFF_CNTL1_1:  rd_val = st_q.ana1;
            dcg_pkg::OFF_CLKGEN_0: rd_val = st_q.clk0;
            dcg_pkg::OFF_CLKGEN_1: rd_val = st_q.clk1;
            dcg_pkg::OFF_LS_DIV_0: rd_val = st_q.ls0;
            dcg_pkg::OFF_LS_DIV_1: rd_val = st_q.ls1;
            dcg_pkg::OFF_GLOBAL_A: rd_val = st_q.ga;
            dcg_pkg::OFF_GLOBAL_B: rd_val = st_q.gb;
            dcg_pkg::OFF_GLOBAL_C: rd_val = st_q.gc;
            dcg_pkg::OFF_GLOBAL_D: rd_val = st_q.gd;
            dcg_pkg::OFF_STATUS:   rd_val = {5'h00, run, st_q.sw_rst};
            default:               hit    = 1'b0;
        endcase
    end

    always_comb begin
        st_d        = st_q;
        st_d.sw_rst = 1'b0; // R20
        st_d.x_q    = xtal_s;
        st_d.m0_q   = m0_s;
        st_d.m1_q   = m1_s;
        st_d.x_t    = xtal_s && !st_q.x_q;
        st_d.m0_t   = m0_s && !st_q.m0_q;
        st_d.m1_t   = m1_s && !st_q.m1_q;
        if (!run) begin
            st_d.x_t  = 1'b0;
            st_d.m0_t = 1'b0;
            st_d.m1_t = 1'b0;
        end
        // error flag taken at every setup cycle, so unmapped writes report too
        if (psel && !penable) begin
            st_d.err = !hit;
        end
        if (rd) begin
            st_d.rdata = {25'h000_0000, rd_val}; // R17
        end
        if (wr && run) begin
            case (paddr)
                dcg_pkg::OFF_CNTL0_0:  st_d.pwr0 = pwdata[6:0]; // R18
                dcg_pkg::OFF_CNTL0_1:  st_d.pwr1 = pwdata[6:0];
                dcg_pkg::OFF_CNTL1_0:  st_d.ana0 = pwdata[6:0];
                dcg_pkg::OFF_CNTL1_1:  st_d.ana1 = pwdata[6:0];
                dcg_pkg::OFF_CLKGEN_0: st_d.clk0 = {pwdata[6], hs_clip(pwdata[5:0])}; // R15
                dcg_pkg::OFF_CLKGEN_1: st_d.clk1 = {pwdata[6], hs_clip(pwdata[5:0])}; // R15
                dcg_pkg::OFF_LS_DIV_0: st_d.ls0  = ls_clip(pwdata[6:0]); // R15
                dcg_pkg::OFF_LS_DIV_1: st_d.ls1  = ls_clip(pwdata[6:0]); // R15
                dcg_pkg::OFF_GLOBAL_A: begin
                    st_d.ga     = pwdata[6:0] & ~(7'h01 << dcg_pkg::SWRST_BIT);
                    st_d.sw_rst = pwdata[dcg_pkg::SWRST_BIT]; // R20
                end
                dcg_pkg::OFF_GLOBAL_B: st_d.gb = pwdata[6:0];
                dcg_pkg::OFF_GLOBAL_C: st_d.gc = pwdata[6:0];
                dcg_pkg::OFF_GLOBAL_D: st_d.gd = pwdata[6:0];
                default:               st_d.ga = st_q.ga;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_q      <= '0;
            st_q.pwr0 <= dcg_pkg::RST_CNTL0;
            st_q.pwr1 <= dcg_pkg::RST_CNTL0;
            st_q.ana0 <= dcg_pkg::RST_ZERO;
            st_q.ana1 <= dcg_pkg::RST_ZERO;
            st_q.clk0 <= {1'b0, dcg_pkg::HS_DIV_RST}; // R15 R21
            st_q.clk1 <= {1'b0, dcg_pkg::HS_DIV_RST};
            st_q.ls0  <= dcg_pkg::LS_DIV_RST;
            st_q.ls1  <= dcg_pkg::LS_DIV_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // one chain per codec, each with its own divisor pair
    dcg_divider u_div0 ( // R14
        .sys_clk   (sys_clk),
        .reset     (reset),
        .run       (run),
        .xtal_tick (st_q.x_t),
        .ext_tick  (st_q.m0_t),
        .ext_lvl   (st_q.m0_q),
        .use_ext   (st_q.clk0[dcg_pkg::SEL_BIT]), // R6 R21
        .hs_div    (st_q.clk0[5:0]),
        .ls_div    (st_q.ls0),
        .oversampling_clock   (osr0),
        .osr_tick  (),
        .fs_tick   (fs0)
    );
    dcg_divider u_div1 (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .run       (run),
        .xtal_tick (st_q.x_t),
        .ext_tick  (st_q.m1_t),
        .ext_lvl   (st_q.m1_q),
        .use_ext   (st_q.clk1[dcg_pkg::SEL_BIT]), // R6 R21
        .hs_div    (st_q.clk1[5:0]),
        .ls_div    (st_q.ls1),
        .oversampling_clock   (osr1),
        .osr_tick  (),
        .fs_tick   (fs1)
    );

    assign prdata              = st_q.rdata;
    assign pready              = 1'b1;
    assign pslverr             = psel && penable && st_q.err;
    assign oscillator_enable   = run; // R2
    assign oversampling_clock0 = osr0;
    assign oversampling_clock1 = osr1;
    assign serial_bit_clock0   = osr0; // R7
    assign serial_bit_clock1   = osr1; // R7
    assign sample_tick0        = fs0;
    assign sample_tick1        = fs1;
    assign soft_reset_pulse    = st_q.sw_rst;
    assign codec0_power_ctrl   = st_q.pwr0;
    assign codec1_power_ctrl   = st_q.pwr1;
    assign codec0_analog_ctrl  = st_q.ana0;
    assign codec1_analog_ctrl  = st_q.ana1;
endmodule

/* dcg_pkg.sv */
// dcg_pkg: shared constants for the dual codec clock generator
// assumes an apb master on sys_clk, 100 MHz, and a synchronous active-high reset
// How it works
// R1: external master clock, when selected, is the oversampling clock with no high-speed divide.
// R2: absolute power-down stops the oscillator and halts all block activity.
// R3: controller waits 10 ms after power-down before expecting operation.
// R4: after that startup wait the controller applies a hardware reset.
// R5: a software reset may replace it once serial framing is synced.
// R6: per-codec master clock select chooses crystal or external clock.
// R7: serial bit clock equals the codec oversampling clock.
// R8: integrator supplies clock frequencies that are integer multiples of sample rates.
// R9: software keeps low-speed divisor between 51 and 127.
// R10: oversampling clock stays at or below 4 MHz.
// R11: system to oversampling ratio at least 7 crystal, 8 external.
// R12: at least 580 system clocks per sampling period per active codec.
// R13: crystal and system clock do not exceed 30 MHz; sys_clk is taken as 100 MHz here.
// R14: each codec has its own pair of divisors.
// R15: high-speed divisor 7..63 reset 16, low-speed 51..127 reset 51.
// R16: with external clock only the low-speed divisor applies.
// R17: ten 8-bit registers whose top bit always reads zero; the code maps twelve plus a status register.
// R18: per-codec and global registers reachable from either port.
// R19: suffix 0 registers control codec 0, suffix 1 codec 1.
// R20: register bits hold statically except the software reset bit.
// R21: select bit clear sources crystal, set sources external clock.
// R22: crystal timing: osr is xtal over high divisor, fs is osr over twice low divisor.
package dcg_pkg;
    localparam int unsigned ADDR_W        = 6;
    localparam logic [5:0] OFF_CNTL0_0    = 6'h00;
    localparam logic [5:0] OFF_CNTL0_1    = 6'h04;
    localparam logic [5:0] OFF_CNTL1_0    = 6'h08;
    localparam logic [5:0] OFF_CNTL1_1    = 6'h0C;
    localparam logic [5:0] OFF_CLKGEN_0   = 6'h10;
    localparam logic [5:0] OFF_CLKGEN_1   = 6'h14;
    localparam logic [5:0] OFF_LS_DIV_0   = 6'h18;
    localparam logic [5:0] OFF_LS_DIV_1   = 6'h1C;
    localparam logic [5:0] OFF_GLOBAL_A   = 6'h20;
    localparam logic [5:0] OFF_GLOBAL_B   = 6'h24;
    localparam logic [5:0] OFF_GLOBAL_C   = 6'h28;
    localparam logic [5:0] OFF_GLOBAL_D   = 6'h2C;
    localparam logic [5:0] OFF_STATUS     = 6'h30;
    localparam logic [6:0] RST_CNTL0      = 7'h0C;
    localparam logic [6:0] RST_ZERO       = 7'h00;
    localparam logic [5:0] HS_DIV_MIN     = 6'h07;
    localparam logic [5:0] HS_DIV_MAX     = 6'h3F;
    localparam logic [5:0] HS_DIV_RST     = 6'h10;
    localparam logic [6:0] LS_DIV_MIN     = 7'h33;
    localparam logic [6:0] LS_DIV_MAX     = 7'h7F;
    localparam logic [6:0] LS_DIV_RST     = 7'h33;
    localparam int unsigned SEL_BIT       = 6;
    localparam int unsigned SWRST_BIT     = 4;
    localparam int unsigned SYS_CLK_MHZ   = 100;
    localparam int unsigned STARTUP_MS    = 10;
    localparam int unsigned STARTUP_CYC   = STARTUP_MS * SYS_CLK_MHZ * 1000;
endpackage

/* dcg_sync3.sv */
// dcg_sync3: three-stage synchroniser, change accepted when stages two and three agree
// assumes the input is asynchronous to sys_clk
`timescale 1ns/1ps
module dcg_sync3 (
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic async_in,
    output logic      level_out
);
    typedef struct packed {
        logic [2:0] stg;
        logic       lvl;
    } dcg_sync_st_t;
    dcg_sync_st_t st_q, st_d;
    always_comb begin
        st_d     = st_q;
        st_d.stg = {st_q.stg[1:0], async_in};
        if (st_q.stg[1] == st_q.stg[2]) begin
            st_d.lvl = st_q.stg[2];
        end
    end
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign level_out = st_q.lvl;
endmodule

/* dcg_divider.sv */
// dcg_divider: one codec's clock chain, high-speed then low-speed divide
// assumes reference enables already synchronised to sys_clk
`timescale 1ns/1ps
module dcg_divider (
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       run,
    input  wire logic       xtal_tick,
    input  wire logic       ext_tick,
    input  wire logic       ext_lvl,
    input  wire logic       use_ext,
    input  wire logic [5:0] hs_div,
    input  wire logic [6:0] ls_div,
    output logic            oversampling_clock,
    output logic            osr_tick,
    output logic            fs_tick
);
    typedef struct packed {
        logic [5:0] hs_cnt;
        logic [7:0] ls_cnt;
        logic       osr;
        logic       osr_p;
        logic       fs_p;
    } dcg_div_st_t;
    dcg_div_st_t st_q, st_d;
    logic osr_edge;
    logic [7:0] ls_term;
    always_comb begin
        st_d       = st_q;
        st_d.osr_p = 1'b0;
        st_d.fs_p  = 1'b0;
        osr_edge   = 1'b0;
        ls_term    = {ls_div, 1'b0} - 8'h01;
        if (!run) begin
            st_d = '0; // R2
        end else if (use_ext) begin
            osr_edge = ext_tick; // R1 R16
            // follow the pin level so the bit clock runs at the master clock rate
            st_d.osr = ext_lvl; // R1 R7
            st_d.hs_cnt = '0;
        end else if (xtal_tick) begin
            if (st_q.hs_cnt >= hs_div - 6'h01) begin // R22
                st_d.hs_cnt = '0;
                osr_edge    = 1'b1;
                st_d.osr    = 1'b1;
            end else begin
                st_d.hs_cnt = st_q.hs_cnt + 6'h01;
                if (st_q.hs_cnt == {1'b0, hs_div[5:1]} - 6'h01) begin
                    st_d.osr = 1'b0;
                end
            end
        end
        if (run && osr_edge) begin
            st_d.osr_p = 1'b1;
            if (st_q.ls_cnt >= ls_term) begin // R22
                st_d.ls_cnt = '0;
                st_d.fs_p   = 1'b1;
            end else begin
                st_d.ls_cnt = st_q.ls_cnt + 8'h01;
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign oversampling_clock  = st_q.osr; // R7
    assign osr_tick = st_q.osr_p;
    assign fs_tick  = st_q.fs_p;
endmodule

/* dcg_checker.sv */
// dcg_checker: port-level assertions for the dual codec clock generator
// assumes the top module ports only; attached by the bind at the foot
`timescale 1ns/1ps
module dcg_checker (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [5:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        absolute_powerdown_in_n,
    input wire logic        oscillator_enable,
    input wire logic        oversampling_clock0,
    input wire logic        oversampling_clock1,
    input wire logic        serial_bit_clock0,
    input wire logic        serial_bit_clock1,
    input wire logic        sample_tick0,
    input wire logic        sample_tick1,
    input wire logic        soft_reset_pulse
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    AST_PREADY: assert property (pready) else $error("pready low");
    AST_MSB_ZERO: assert property (prdata[31:7] == 25'h0)
        else $error("read data above bit 6 not zero");
    AST_BCLK0: assert property (serial_bit_clock0 == oversampling_clock0)
        else $error("bit clock 0 differs from oversampling clock 0");
    AST_BCLK1: assert property (serial_bit_clock1 == oversampling_clock1)
        else $error("bit clock 1 differs from oversampling clock 1");
    // six cycles covers the three-stage synchroniser plus its output stage
    AST_PD_STOP: assert property (!absolute_powerdown_in_n [*6] |-> !oscillator_enable)
        else $error("oscillator still enabled in power-down");
    AST_PD_HALT: assert property (!oscillator_enable [*3] |->
        !(oversampling_clock0 || oversampling_clock1 || sample_tick0 || sample_tick1))
        else $error("clock activity while oscillator stopped");
    AST_TICK0: assert property (sample_tick0 |=> !sample_tick0 [*8])
        else $error("sample tick 0 too close");
    AST_TICK1: assert property (sample_tick1 |=> !sample_tick1 [*8])
        else $error("sample tick 1 too close");
    AST_SWRST: assert property (psel && penable && pwrite && paddr == dcg_pkg::OFF_GLOBAL_A && oscillator_enable
        && pwdata[dcg_pkg::SWRST_BIT] |=> soft_reset_pulse ##1 !soft_reset_pulse)
        else $error("software reset pulse missing or too long");
    AST_UNMAPPED: assert property (psel && penable && paddr > dcg_pkg::OFF_STATUS |-> pslverr)
        else $error("unmapped access without error");
endmodule

bind dcg_clock_gen dcg_checker i_dcg_checker (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .absolute_powerdown_in_n(absolute_powerdown_in_n), .oscillator_enable(oscillator_enable),
    .oversampling_clock0(oversampling_clock0), .oversampling_clock1(oversampling_clock1),
    .serial_bit_clock0(serial_bit_clock0), .serial_bit_clock1(serial_bit_clock1), .sample_tick0(sample_tick0),
    .sample_tick1(sample_tick1), .soft_reset_pulse(soft_reset_pulse));

/* dcg_clk_source.sv */
// dcg_clk_source: crystal and external master clock sources
// assumes 1 ns units; the crystal only swings while the device keeps its oscillator on
`timescale 1ns/1ps
module dcg_clk_source #(
    parameter int XTAL_HALF = 20,
    parameter int EXT_HALF  = 160
) (
    input  wire logic run,
    output logic      crystal_clock_in,
    output logic      codec0_ext_oversample_clk,
    output logic      codec1_ext_oversample_clk
);
    // 25 MHz crystal, under the 30 MHz ceiling
    // every divisor pair used leaves at least 580 crystal cycles per sample
    initial begin
        crystal_clock_in = 1'b0;
        #3;
        forever begin
            #(XTAL_HALF);
            crystal_clock_in = run ? ~crystal_clock_in : 1'b0;
        end
    end

    // 3.125 MHz: eight crystal cycles each, below 4 MHz
    // opposite phases so the two codec paths never see the same edge
    initial begin
        codec0_ext_oversample_clk = 1'b0;
        codec1_ext_oversample_clk = 1'b1;
        #7;
        forever begin
            #(EXT_HALF);
            codec0_ext_oversample_clk = ~codec0_ext_oversample_clk;
            codec1_ext_oversample_clk = ~codec1_ext_oversample_clk;
        end
    end
endmodule

/* dual_codec_clock_divider_gen_tb.sv */
// dual_codec_clock_divider_gen_tb: register and sample period checks
// assumes the clock source model and the bound checker are compiled alongside
`timescale 1ns/1ps
module dual_codec_clock_divider_gen_tb;
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [5:0]  paddr = 6'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        pd_n = 1'b1;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        osc_en;
    logic        xtal;
    logic        ext0;
    logic        ext1;
    wire  [1:0]  tick;
    logic [32:0] exp_q[$];
    int          sq[2][$];
    int          cnt[2];
    bit          seen[2];
    int          err_count = 0;
    int          checked = 0;
    int          cyc = 0;

    always #5 sys_clk = ~sys_clk;

    dcg_clock_gen i_dcg_clock_gen (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .crystal_clock_in(xtal), .codec0_ext_oversample_clk(ext0), .codec1_ext_oversample_clk(ext1),
        .absolute_powerdown_in_n(pd_n), .oscillator_enable(osc_en), .oversampling_clock0(),
        .oversampling_clock1(), .serial_bit_clock0(), .serial_bit_clock1(), .sample_tick0(tick[0]),
        .sample_tick1(tick[1]), .soft_reset_pulse(), .codec0_power_ctrl(), .codec1_power_ctrl(),
        .codec0_analog_ctrl(), .codec1_analog_ctrl());

    dcg_clk_source i_dcg_clk_source (.run(osc_en), .crystal_clock_in(xtal), .codec0_ext_oversample_clk(ext0),
        .codec1_ext_oversample_clk(ext1));

    task automatic close_out();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic cmp(input logic [32:0] exp, input logic [32:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH read expected %h seen %h", exp, got);
        end
    endtask

    // one cycle of slack absorbs the synchroniser phase
    task automatic cmp_span(input int exp, input int got);
        checked++;
        if (got < exp - 1 || got > exp + 1) begin
            err_count++;
            $display("MISMATCH sample period expected %0d seen %0d", exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [5:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [5:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0000_0000);
    endtask

    task automatic spans(input int e0, input int e1);
        sq[0].push_back(e0);
        sq[1].push_back(e1);
        while (sq[0].size() + sq[1].size() != 0) @(posedge sys_clk);
    endtask

    task automatic hw_reset();
        reset <= 1'b1;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        while (osc_en !== 1'b1) @(posedge sys_clk);
    endtask

    function automatic logic [32:0] dflt(input int i);
        case (i)
            0, 1: return {26'h0, dcg_pkg::RST_CNTL0};
            4, 5: return {27'h0, dcg_pkg::HS_DIV_RST};
            6, 7: return {26'h0, dcg_pkg::LS_DIV_RST};
            default: return 33'h0_0000_0000;
        endcase
    endfunction

    always @(posedge sys_clk) begin
        cyc++;
        if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0) cmp(exp_q.pop_front(), {pslverr, prdata});
        for (int c = 0; c < 2; c++) begin
            cnt[c]++;
            if (tick[c] === 1'b1) begin
                if (seen[c] && sq[c].size() > 0) cmp_span(sq[c].pop_front(), cnt[c]);
                seen[c] = sq[c].size() > 0;
                cnt[c] = 0;
            end
        end
        if (cyc == 95000) begin
            err_count++;
            close_out();
        end
    end

    initial begin
        logic [6:0] v0;
        logic [6:0] v1;
        int         ls;
        void'($urandom(47293));
        v0 = 7'($urandom());
        v1 = 7'($urandom());
        ls = 51 + $urandom() % 77;
        hw_reset();
        for (int i = 0; i < 12; i++) rd(6'(i * 4), dflt(i));
        rd(6'h34, 33'h1_0000_0000);
        apb(1'b1, dcg_pkg::OFF_GLOBAL_A, 32'h0000_0010);
        rd(dcg_pkg::OFF_GLOBAL_A, 33'h0_0000_0000);
        spans(6528, 6528);
        apb(1'b1, dcg_pkg::OFF_CNTL0_0, 32'hFFFF_FFFF);
        rd(dcg_pkg::OFF_CNTL0_0, 33'h0_0000_007F);
        rd(dcg_pkg::OFF_CNTL0_1, {26'h0, dcg_pkg::RST_CNTL0});
        apb(1'b1, dcg_pkg::OFF_CNTL1_0, {25'h0, v0});
        apb(1'b1, dcg_pkg::OFF_CNTL1_1, {25'h0, v1});
        rd(dcg_pkg::OFF_CNTL1_0, {26'h0, v0});
        rd(dcg_pkg::OFF_CNTL1_1, {26'h0, v1});
        apb(1'b1, dcg_pkg::OFF_CLKGEN_1, 32'h0000_0003);
        rd(dcg_pkg::OFF_CLKGEN_1, 33'h0_0000_0007);
        apb(1'b1, dcg_pkg::OFF_LS_DIV_1, 32'h0000_0010);
        rd(dcg_pkg::OFF_LS_DIV_1, 33'h0_0000_0033);
        apb(1'b1, dcg_pkg::OFF_LS_DIV_1, 32'h0000_007F);
        rd(dcg_pkg::OFF_LS_DIV_1, 33'h0_0000_007F);
        apb(1'b1, dcg_pkg::OFF_CLKGEN_0, 32'h0000_007F);
        spans(3264, 7112);
        apb(1'b1, dcg_pkg::OFF_CLKGEN_0, 32'h0000_0007);
        apb(1'b1, dcg_pkg::OFF_LS_DIV_1, 32'(ls));
        spans(2856, 56 * ls);
        pd_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        apb(1'b1, dcg_pkg::OFF_CNTL1_0, {25'h0, ~v0});
        pd_n <= 1'b1;
        while (osc_en !== 1'b1) @(posedge sys_clk);
        rd(dcg_pkg::OFF_CNTL1_0, {26'h0, v0});
        // startup wait shortened: the 10 ms figure would dwarf the whole run
        repeat (200) @(posedge sys_clk);
        hw_reset();
        rd(dcg_pkg::OFF_CNTL1_0, 33'h0_0000_0000);
        rd(dcg_pkg::OFF_CLKGEN_0, {27'h0, dcg_pkg::HS_DIV_RST});
        // software reset as the alternative restart, then the status word: running, pulse gone
        apb(1'b1, dcg_pkg::OFF_GLOBAL_A, 32'h0000_0010);
        rd(dcg_pkg::OFF_STATUS, 33'h0_0000_0002);
        close_out();
    end
endmodule
